/* File: logic/external_bus_ctrl.sv */
// External bus controller: window decode, bus cycle sequencer and pin drivers.
// Function
// (RQ1) Single-chip mode plus four external modes, 16 or 8 bit, muxed or demuxed.
// (RQ2) Demuxed: address on address-only port, data on full port or low byte.
// (RQ3) Muxed: address then data on shared port; address-only port unused.
// (RQ4) Programmable count of segment lines bounds space from 64 Kbytes to 8 Mbytes.
// (RQ5) Up to four chip selects: three windows plus the default.
// (RQ6) Each region applies its own timing and function settings to every access.
// (RQ7) Up to four independently programmable address windows.
// (RQ8) Window four beats three, window two beats one on overlap.
// (RQ9) Accesses outside all windows use default settings, set zero.
// (RQ10) Active window drives its chip select; window four has no pin.
// (RQ11) All bus timing follows the rising edge of the reference clock output.
// (RQ12) Internal peripheral bus accesses use the same access mechanism.
// (RQ13) Bus mode switches per access according to the hit window.
// (RQ14) Reads of undefined flash register locations return a trap code.
// (RQ15) External RAM or ROM may cover about 12 Mbytes of the map.
// (RQ16) Single-chip mode starts no external cycle; pins stay inactive. The reference clock output keeps toggling.
`timescale 1ns/1ps
`default_nettype none
module external_bus_ctrl
    import xbc_pkg::*;
#(
    parameter logic [DATA_W-1:0] TRAP_CODE = 16'hffff
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     single_chip_mode,
    input  wire logic [2:0]               seg_lines_sel,
    input  wire logic [TIM_W-1:0]         default_timing_config,
    input  wire logic [FUN_W-1:0]         default_function_config,
    input  wire logic [N_WIN*RANGE_W-1:0] window_range_select,
    input  wire logic [N_WIN*TIM_W-1:0]   window_timing_config,
    input  wire logic [N_WIN*FUN_W-1:0]   window_function_config,
    input  wire logic                     flash_reg_defined,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    input  wire logic [ADDR_W-1:0]        req_addr,
    input  wire logic                     req_write,
    input  wire logic                     req_byte,
    input  wire logic [DATA_W-1:0]        req_wdata,
    output logic                          resp_valid,
    output logic      [DATA_W-1:0]        resp_rdata,
    output logic                          resp_trap,
    output logic                          internal_peripheral_bus_req,
    output logic      [ADDR_W-1:0]        internal_peripheral_bus_addr,
    output logic                          internal_peripheral_bus_write,
    output logic      [DATA_W-1:0]        internal_peripheral_bus_wdata,
    input  wire logic [DATA_W-1:0]        internal_peripheral_bus_rdata,
    input  wire logic                     internal_peripheral_bus_ack,
    output logic                          bus_reference_clock_out,
    output logic                          ale,
    output logic                          rd_n,
    output logic                          wr_n,
    output logic                          bhe_n,
    output logic      [15:0]              address_only_port,
    output logic                          address_only_port_oe,
    input  wire logic [DATA_W-1:0]        shared_addr_data_port_in,
    output logic      [DATA_W-1:0]        shared_addr_data_port_out,
    output logic      [1:0]               shared_addr_data_port_oe,
    output logic      [SEG_LINES-1:0]     seg_addr_out,
    output logic      [SEG_LINES-1:0]     seg_addr_oe,
    output logic      [3:0]               chip_sel_n,
    output logic      [2:0]               active_window
);
    xbc_state_t st_q, st_d;

    logic [4:0]            ref_cnt_q;
    logic                  ref_clk_q;
    logic [DATA_W-1:0]     din_s1_q, din_s2_q;
    logic [ADDR_W-1:0]     addr_q;
    logic [DATA_W-1:0]     wdata_q;
    logic                  write_q, byte_q, csen_q;
    xbc_mode_t             mode_q;
    logic [2:0]            win_q;
    logic [TIM_ALE_W-1:0]  ale_cnt_q, ale_cnt_d;
    logic [TIM_WAIT_W-1:0] wait_cnt_q, wait_cnt_d;
    logic                  resp_valid_q, resp_trap_q;
    logic [DATA_W-1:0]     resp_rdata_q;

    // Reference clock divider; ref_rise marks the clk edge on which the output rises.
    wire logic ref_last = (ref_cnt_q == REF_HALF_LAST);
    wire logic ref_rise = ref_last && !ref_clk_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_cnt_q <= 5'h00;
            ref_clk_q <= 1'b0;
        end else begin
            ref_cnt_q <= ref_last ? 5'h00 : 5'(ref_cnt_q + 5'h01);
            ref_clk_q <= ref_last ? !ref_clk_q : ref_clk_q;
        end
    end
    assign bus_reference_clock_out = ref_clk_q;

    // Shared port read data comes from outside the clock domain: two flops first.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end else begin
            din_s1_q <= shared_addr_data_port_in;
            din_s2_q <= din_s1_q;
        end
    end

    // Window decode of the incoming request address.
    logic [2:0] win_hit;
    xbc_window_match u_match (
        .addr      (req_addr),
        .range_sel (window_range_select),
        .win_idx   (win_hit)
    );

    // (RQ6) Select the hit region's own timing and function set.
    wire logic [1:0]       wsel    = 2'(win_hit - 3'h1);
    wire logic             is_dflt = (win_hit == WIN_DEFAULT);
    wire logic [TIM_W-1:0] sel_tim = is_dflt ? default_timing_config
                                             : window_timing_config[wsel*TIM_W +: TIM_W];
    wire logic [FUN_W-1:0] sel_fun = is_dflt ? default_function_config
                                             : window_function_config[wsel*FUN_W +: FUN_W];

    // Request classification. Flash registers live behind the internal bus.
    wire logic in_flash = (req_addr[ADDR_W-1 -: RANGE_BASE_W] == FLASH_REG_PAGE);
    wire logic to_int   = sel_fun[FUN_INT_BIT] || in_flash;
    // (RQ14) Undefined flash register read traps.
    wire logic trap_rd  = in_flash && !flash_reg_defined && !req_write;
    // Writes to undefined flash locations are dropped without a bus cycle.
    wire logic drop_wr  = in_flash && !flash_reg_defined && req_write;
    // (RQ16) No external cycle in single-chip mode.
    wire logic ext_off  = !to_int && single_chip_mode;

    assign req_ready = (st_q == ST_IDLE);
    wire logic take  = req_valid && req_ready;

    // (RQ1) Decode the latched bus mode.
    wire logic is_mux = (mode_q == MODE_MUX16) || (mode_q == MODE_MUX8);
    wire logic is16   = (mode_q == MODE_MUX16) || (mode_q == MODE_DEMUX16);
    wire logic ext_on = (st_q == ST_ADDR) || (st_q == ST_DATA);

    // Sequencer next state; every external phase boundary sits on ref_rise.
    always_comb begin
        st_d       = st_q;
        ale_cnt_d  = ale_cnt_q;
        wait_cnt_d = wait_cnt_q;
        unique case (st_q)
            ST_IDLE: begin
                if (take && !trap_rd && !drop_wr && !ext_off) begin
                    // (RQ12) Internal bus uses the same request path.
                    st_d       = to_int ? ST_IPB : ST_START;
                    ale_cnt_d  = sel_tim[TIM_ALE_LSB +: TIM_ALE_W];
                    wait_cnt_d = sel_tim[TIM_WAIT_LSB +: TIM_WAIT_W];
                end
            end
            ST_START: begin
                // (RQ11) Cycle starts on reference rise.
                if (ref_rise) begin
                    st_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (ref_rise) begin
                    if (ale_cnt_q == 2'h0) begin
                        st_d = ST_DATA;
                    end else begin
                        ale_cnt_d = 2'(ale_cnt_q - 2'h1);
                    end
                end
            end
            ST_DATA: begin
                if (ref_rise) begin
                    if (wait_cnt_q == 4'h0) begin
                        st_d = ST_IDLE;
                    end else begin
                        wait_cnt_d = 4'(wait_cnt_q - 4'h1);
                    end
                end
            end
            ST_IPB: begin
                if (internal_peripheral_bus_ack) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q       <= ST_IDLE;
            ale_cnt_q  <= 2'h0;
            wait_cnt_q <= 4'h0;
        end else begin
            st_q       <= st_d;
            ale_cnt_q  <= ale_cnt_d;
            wait_cnt_q <= wait_cnt_d;
        end
    end

    // Access latch. Settings are captured per access so modes may differ back to back.
    // (RQ15) Full 24-bit address.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_q  <= 24'h00_0000;
            wdata_q <= 16'h0000;
            write_q <= 1'b0;
            byte_q  <= 1'b0;
            csen_q  <= 1'b0;
            mode_q  <= MODE_DEMUX16;
            win_q   <= WIN_DEFAULT;
        end else if (take) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
            byte_q  <= req_byte;
            csen_q  <= sel_fun[FUN_CSEN_BIT];
            // (RQ13) Mode switches per access.
            mode_q  <= xbc_mode_t'(sel_fun[FUN_MODE_LSB +: 2]);
            win_q   <= win_hit;
        end
    end

    // Answer data: an 8-bit bus returns its byte on both lanes.
    wire logic ext_end = (st_q == ST_DATA) && ref_rise && (wait_cnt_q == 4'h0);
    wire logic ipb_end = (st_q == ST_IPB) && internal_peripheral_bus_ack;
    wire logic imm_end = take && (trap_rd || drop_wr || ext_off);
    wire logic [DATA_W-1:0] ext_rd = is16 ? din_s2_q : {din_s2_q[7:0], din_s2_q[7:0]};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_valid_q <= 1'b0;
            resp_trap_q  <= 1'b0;
            resp_rdata_q <= 16'h0000;
        end else begin
            resp_valid_q <= ext_end || ipb_end || imm_end;
            resp_trap_q  <= imm_end && (trap_rd || ext_off);
            if (ext_end) begin
                resp_rdata_q <= write_q ? 16'h0000 : ext_rd;
            end else if (ipb_end) begin
                resp_rdata_q <= write_q ? 16'h0000 : internal_peripheral_bus_rdata;
            end else if (imm_end) begin
                // (RQ14) Trap code instead of data.
                resp_rdata_q <= trap_rd ? TRAP_CODE : 16'h0000;
            end
        end
    end
    assign resp_valid = resp_valid_q;
    assign resp_trap  = resp_trap_q;
    assign resp_rdata = resp_rdata_q;

    // Internal peripheral bus: request held as a level until acknowledged.
    assign internal_peripheral_bus_req   = (st_q == ST_IPB);
    assign internal_peripheral_bus_addr  = addr_q;
    assign internal_peripheral_bus_write = write_q;
    assign internal_peripheral_bus_wdata = wdata_q;

    // Strobes; only ADDR and DATA ever leave the chip, so single-chip mode stays quiet.
    // (RQ16) Strobes idle outside a cycle.
    assign ale   = (st_q == ST_ADDR);
    assign rd_n  = !((st_q == ST_DATA) && !write_q);
    assign wr_n  = !((st_q == ST_DATA) && write_q);
    assign bhe_n = !(ext_on && is16 && (!byte_q || addr_q[0]));

    // (RQ2) Demuxed address on the address-only port.
    // (RQ3) Muxed modes leave the address-only port undriven.
    assign address_only_port_oe = ext_on && !is_mux;
    assign address_only_port    = address_only_port_oe ? addr_q[15:0] : 16'h0000;

    // Shared port: muxed address phase, then write data on full port or low byte.
    // An 8-bit bus carries an odd-addressed byte on its low lane.
    wire logic drv_adr = (st_q == ST_ADDR) && is_mux;
    wire logic drv_dat = (st_q == ST_DATA) && write_q;
    wire logic [DATA_W-1:0] wr_lane = is16 ? wdata_q :
                                      {8'h00, (addr_q[0] ? wdata_q[15:8] : wdata_q[7:0])};

    // (RQ3) Address then data on shared port.
    // (RQ2) Data width follows bus mode.
    assign shared_addr_data_port_out = drv_adr ? addr_q[15:0] :
                                       drv_dat ? wr_lane : 16'h0000;
    assign shared_addr_data_port_oe  = drv_adr ? 2'h3 :
                                       drv_dat ? {is16, 1'b1} : 2'h0;

    // Segment lines: only the selected count is driven, which bounds the space.
    // The lines stay driven between cycles so that attached decoders see stable levels.
    genvar s;
    generate
        for (s = 0; s < SEG_LINES; s++) begin : g_seg
            // (RQ4) Programmable segment line count.
            assign seg_addr_oe[s]  = !single_chip_mode && (3'(s) < seg_lines_sel);
            assign seg_addr_out[s] = seg_addr_oe[s] && addr_q[16+s];
        end
    endgenerate

    // Chip selects: pin 0 is the default region, pins 1 to 3 windows one to three.
    // (RQ5) Four chip-select pins.
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_cs
            // (RQ10) Active window selects its pin.
            assign chip_sel_n[c] = !(ext_on && csen_q && (win_q == 3'(c)));
        end
    endgenerate

    // (RQ10) Window four shows only here, never on a select pin.
    assign active_window = (st_q == ST_IDLE) ? WIN_DEFAULT : win_q;
endmodule : external_bus_ctrl
`default_nettype wire

/* File: logic/xbc_pkg.sv */
// Shared constants and types of the external bus controller.
`default_nettype none
package xbc_pkg;
    // Widths of the processor side and of the external bus.
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int SEG_LINES = 7;     // Segment lines A16 to A22, 64 Kbytes up to 8 Mbytes.
    localparam int N_WIN     = 4;

    // Address window range select layout: base of address bits 23..12, size code.
    localparam int RANGE_W        = 16;
    localparam int RANGE_SIZE_LSB = 0;
    localparam int RANGE_SIZE_W   = 4;
    localparam int RANGE_BASE_LSB = 4;
    localparam int RANGE_BASE_W   = 12;

    // Timing configuration layout: data phase wait states, extra address phases.
    localparam int TIM_W        = 6;
    localparam int TIM_WAIT_LSB = 0;
    localparam int TIM_WAIT_W   = 4;
    localparam int TIM_ALE_LSB  = 4;
    localparam int TIM_ALE_W    = 2;

    // Function configuration layout: bus mode, chip select enable, internal bus target.
    localparam int FUN_W        = 4;
    localparam int FUN_MODE_LSB = 0;
    localparam int FUN_CSEN_BIT = 2;
    localparam int FUN_INT_BIT  = 3;

    // The topmost 4 Kbytes hold flash registers only.
    localparam logic [RANGE_BASE_W-1:0] FLASH_REG_PAGE = 12'hfff;
    // External RAM and ROM may cover about this many Mbytes of the map.
    localparam int EXT_SPACE_MBYTES = 12;

    // Reference clock: figures in ns, half period in clk cycles rounded down.
    localparam int CLK_PERIOD_NS = 4;
    localparam int REF_PERIOD_NS = 125;
    localparam int REF_HALF_CYC  = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [4:0] REF_HALF_LAST = 5'(REF_HALF_CYC - 1);

    // Window number that has no chip select pin.
    localparam logic [2:0] WIN_NO_PIN = 3'h4;
    localparam logic [2:0] WIN_DEFAULT = 3'h0;

    typedef enum logic [1:0] {
        MODE_DEMUX16 = 2'h0,
        MODE_MUX16   = 2'h1,
        MODE_MUX8    = 2'h2,
        MODE_DEMUX8  = 2'h3
    } xbc_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_ADDR  = 5'h04,
        ST_DATA  = 5'h08,
        ST_IPB   = 5'h10
    } xbc_state_t;
endpackage : xbc_pkg
`default_nettype wire

/* File: logic/xbc_window_match.sv */
// Address window decoder with fixed priority between the four windows.
`timescale 1ns/1ps
`default_nettype none
module xbc_window_match
    import xbc_pkg::*;
(
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic [N_WIN*RANGE_W-1:0] range_sel,
    output logic      [2:0]               win_idx
);
    logic [N_WIN-1:0] hit;

    // Each window compares the masked upper address; size code zero disables it.
    genvar g;
    generate
        for (g = 0; g < N_WIN; g++) begin : g_win
            wire logic [RANGE_BASE_W-1:0] base;
            wire logic [RANGE_SIZE_W-1:0] size;
            wire logic [RANGE_BASE_W-1:0] mask;
            assign base = range_sel[g*RANGE_W+RANGE_BASE_LSB +: RANGE_BASE_W];
            assign size = range_sel[g*RANGE_W+RANGE_SIZE_LSB +: RANGE_SIZE_W];
            assign mask = 12'hfff << 4'(size - 4'h1);
            // (RQ7) Independent window match.
            assign hit[g] = (size != 4'h0) &&
                            ((addr[ADDR_W-1 -: RANGE_BASE_W] & mask) == (base & mask));
        end
    endgenerate

    // (RQ8) Higher window overrides lower.
    // (RQ9) Default set zero.
    assign win_idx = hit[3] ? 3'h4 :
                     hit[2] ? 3'h3 :
                     hit[1] ? 3'h2 :
                     hit[0] ? 3'h1 : WIN_DEFAULT;
endmodule : xbc_window_match
`default_nettype wire

/* File: verification/external_bus_ctrl_tb.sv */
// Self-checking testbench of the external bus controller.
`timescale 1ns/1ps
`default_nettype none
module external_bus_ctrl_tb
    import xbc_pkg::*;
;
    localparam logic [15:0] TRAP = 16'h5a3c;
    logic clk = 1'b0, sys_rst = 1'b1, single_chip_mode = 1'b0, flash_reg_defined = 1'b0, byte_bus = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_byte = 1'b0, internal_peripheral_bus_ack = 1'b0;
    logic [2:0] seg_lines_sel = 3'h7;
    logic [23:0] req_addr = 24'h00_0000;
    logic [15:0] req_wdata = 16'h0000, internal_peripheral_bus_rdata = 16'h0000;
    logic req_ready, resp_valid, resp_trap, internal_peripheral_bus_req, internal_peripheral_bus_write, got_trap;
    logic bus_reference_clock_out, ale, rd_n, wr_n, bhe_n, address_only_port_oe, addr_on_shared;
    logic [15:0] resp_rdata, internal_peripheral_bus_wdata, address_only_port, shared_addr_data_port_in;
    logic [15:0] shared_addr_data_port_out, got_rdata;
    logic [23:0] internal_peripheral_bus_addr;
    logic [1:0] shared_addr_data_port_oe;
    logic [6:0] seg_addr_out, seg_addr_oe;
    logic [3:0] chip_sel_n;
    logic [4:0] cs_acc;
    logic [2:0] active_window, win_seen;
    logic [16:0] ipb_seen;
    int fails = 0, compares = 0, cycles = 0, rd_len = 0;
    // Windows 1/2 overlap at 10_0000, 3/4 at 20_0000; one mode each.
    external_bus_ctrl #(.TRAP_CODE(TRAP)) external_bus_ctrl_inst (
        .clk, .sys_rst, .single_chip_mode, .seg_lines_sel, .flash_reg_defined,
        .default_timing_config(6'h01), .default_function_config(4'h4),
        .window_range_select(64'h2001_2002_1001_1005), .window_timing_config(24'h00_0402),
        .window_function_config(16'h7654), .req_valid, .req_ready, .req_addr, .req_write, .req_byte,
        .req_wdata, .resp_valid, .resp_rdata, .resp_trap, .internal_peripheral_bus_req,
        .internal_peripheral_bus_addr, .internal_peripheral_bus_write, .internal_peripheral_bus_wdata,
        .internal_peripheral_bus_rdata, .internal_peripheral_bus_ack, .bus_reference_clock_out, .ale,
        .rd_n, .wr_n, .bhe_n, .address_only_port, .address_only_port_oe, .shared_addr_data_port_in,
        .shared_addr_data_port_out, .shared_addr_data_port_oe, .seg_addr_out, .seg_addr_oe,
        .chip_sel_n, .active_window
    );
    xbc_ext_mem xbc_ext_mem_inst (
        .clk, .byte_bus, .ale, .rd_n, .wr_n, .address_only_port, .address_only_port_oe,
        .shared_addr_data_port_out, .shared_addr_data_port_in, .addr_on_shared
    );
    always #2 clk = ~clk;
    // Peripheral acks after one cycle; a monitor records each access.
    always @(posedge clk) begin
        cycles++;
        internal_peripheral_bus_ack <= internal_peripheral_bus_req && !internal_peripheral_bus_ack;
        internal_peripheral_bus_rdata <= internal_peripheral_bus_addr[15:0] ^ 16'h5555;
        if (internal_peripheral_bus_ack) ipb_seen <= {internal_peripheral_bus_write, internal_peripheral_bus_wdata};
        if (req_valid && req_ready) begin
            cs_acc <= 5'h1f;
            rd_len <= 0;
            win_seen <= 3'h7;
        end else begin
            cs_acc <= cs_acc & {bhe_n, chip_sel_n};
            rd_len <= rd_len + int'(!rd_n);
            if (ale) win_seen <= active_window;
        end
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic check_value(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_value
    // One request held until taken, then the answer is awaited.
    task automatic access(input logic [23:0] a, input logic w, input logic b, input logic [15:0] d);
        req_valid <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_byte <= b;
        req_wdata <= d;
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        do @(posedge clk); while (resp_valid !== 1'b1);
        got_rdata = resp_rdata;
        got_trap = resp_trap;
    endtask : access
    // Write, read back and check how the cycle ran.
    task automatic ext_pair(input logic [23:0] a, input logic b, input logic [2:0] win, input logic mx,
                            input int wt, input logic [15:0] d);
        logic [3:0] cs;
        logic [7:0] by;
        cs = (win == 3'h4) ? 4'hf : ~(4'h1 << win);
        by = a[0] ? d[15:8] : d[7:0];
        byte_bus <= b;
        access(a, 1'b1, b, d);
        access(a, 1'b0, b, d);
        check_value("read data", b ? {by, by} : d, got_rdata);
        check_value("window", win, win_seen);
        check_value("selects and bhe", {b, cs}, cs_acc);
        check_value("address on shared port", mx, addr_on_shared);
        check_value("read strobe cycles", 2 * REF_HALF_CYC * (1 + wt), rd_len);
        check_value("segment address", a[22:16], seg_addr_out);
    endtask : ext_pair
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // Windows back to back, flash page, segment lines, single chip.
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check_value("ready after reset", 24'h1, req_ready);
        check_value("selects after reset", 24'hf, chip_sel_n);
        ext_pair(24'h00_0010, 1'b0, 3'h0, 1'b0, 1, 16'ha5c3);
        ext_pair(24'h10_8000, 1'b0, 3'h1, 1'b0, 2, 16'h1e2d);
        ext_pair(24'h10_0020, 1'b0, 3'h2, 1'b1, 0, 16'h3c4b);
        ext_pair(24'h20_1005, 1'b1, 3'h3, 1'b1, 0, 16'h9600);
        ext_pair(24'h20_0004, 1'b1, 3'h4, 1'b0, 0, 16'h0087);
        access(24'hff_f010, 1'b0, 1'b0, 16'h0000);
        check_value("trap flag", 24'h1, got_trap);
        check_value("trap code", TRAP, got_rdata);
        flash_reg_defined <= 1'b1;
        access(24'hff_f012, 1'b1, 1'b0, 16'h1234);
        check_value("internal write", 24'h1_1234, ipb_seen);
        access(24'hff_f012, 1'b0, 1'b0, 16'h0000);
        check_value("internal read", 24'ha547, got_rdata);
        check_value("internal selects", 24'h1f, cs_acc);
        for (int i = 0; i < 8; i++) begin
            seg_lines_sel <= 3'(i);
            repeat (2) @(posedge clk);
            check_value("segment enables", ~(24'hff_ffff << i), seg_addr_oe);
        end
        single_chip_mode <= 1'b1;
        access(24'h00_0010, 1'b0, 1'b0, 16'h0000);
        check_value("single chip trap", 24'h1, got_trap);
        check_value("single chip data", 24'h0, got_rdata);
        check_value("single chip selects", 24'h1f, cs_acc);
        check_value("single chip segments", 24'h0, seg_addr_oe);
        print_verdict();
    end
endmodule : external_bus_ctrl_tb
`default_nettype wire

/* File: verification/xbc_ctrl_props.sv */
// Concurrent checks on the external bus controller's ports.
`timescale 1ns/1ps
`default_nettype none
module xbc_ctrl_props
    import xbc_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       single_chip_mode,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       resp_valid,
    input wire logic       internal_peripheral_bus_req,
    input wire logic       internal_peripheral_bus_ack,
    input wire logic       bus_reference_clock_out,
    input wire logic       ale,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       address_only_port_oe,
    input wire logic [1:0] shared_addr_data_port_oe,
    input wire logic [3:0] chip_sel_n,
    input wire logic [2:0] active_window
);
    // Controller clock; checks rest in reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Reference clock stays high fifteen cycles; strobes move only on its rise.
    a_ref_high_time: assert property ($rose(bus_reference_clock_out) |->
        ##14 bus_reference_clock_out ##1 !bus_reference_clock_out) else $error("reference high phase wrong");
    a_pins_on_ref: assert property ($changed({ale, rd_n, wr_n}) |-> $rose(bus_reference_clock_out))
        else $error("bus strobe moved off the reference rise");
    // Selects, ALE and both port drives stay off in single-chip operation.
    a_single_chip_quiet: assert property (single_chip_mode |-> chip_sel_n == 4'hf && !ale
        && !address_only_port_oe && shared_addr_data_port_oe == 2'h0) else $error("pins active in single chip");
    // At most one select low, and none for the fourth window.
    a_cs_onehot: assert property ($onehot0(~chip_sel_n)) else $error("two chip selects low");
    a_win4_no_pin: assert property (active_window == 3'h4 |-> chip_sel_n == 4'hf)
        else $error("fourth window drove a select");
    // Busy after a take; answered within the longest cycle.
    a_busy_after_take: assert property (req_valid && req_ready |=> !req_ready || resp_valid)
        else $error("ready high while an access is open");
    a_answer_bounded: assert property (req_valid && req_ready |-> ##[1:700] resp_valid)
        else $error("access not answered in time");
    a_ipb_ack_answer: assert property (internal_peripheral_bus_ack |=> resp_valid
        && !internal_peripheral_bus_req) else $error("internal acknowledge not answered");
    // Read strobe is exclusive.
    a_strobe_excl: assert property (!rd_n |-> wr_n && !ale) else $error("read strobe overlaps");
endmodule : xbc_ctrl_props
bind external_bus_ctrl xbc_ctrl_props xbc_ctrl_props_inst (
    .clk, .sys_rst, .single_chip_mode, .req_valid, .req_ready, .resp_valid,
    .internal_peripheral_bus_req, .internal_peripheral_bus_ack, .bus_reference_clock_out,
    .ale, .rd_n, .wr_n, .address_only_port_oe, .shared_addr_data_port_oe, .chip_sel_n, .active_window
);
`default_nettype wire

/* File: verification/xbc_ext_mem.sv */
// External memory model answering the controller's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module xbc_ext_mem (
    input  wire logic        clk,
    input  wire logic        byte_bus,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] address_only_port,
    input  wire logic        address_only_port_oe,
    input  wire logic [15:0] shared_addr_data_port_out,
    output logic      [15:0] shared_addr_data_port_in,
    output logic             addr_on_shared
);
    logic [7:0]  mem [512];
    logic [8:0]  a_q;
    logic [15:0] last_q = 16'h0000;
    logic [7:0]  hi_byte;
    // A byte device floats its high lane: it shows a toggling pattern.
    assign hi_byte = byte_bus ? ~last_q[15:8] : mem[{a_q[8:1], 1'b1}];
    assign shared_addr_data_port_in = !rd_n ? {hi_byte, mem[byte_bus ? a_q : {a_q[8:1], 1'b0}]} : ~last_q;
    always @(posedge clk) begin
        last_q <= shared_addr_data_port_in;
        if (ale) begin
            a_q <= address_only_port_oe ? address_only_port[8:0] : shared_addr_data_port_out[8:0];
            addr_on_shared <= !address_only_port_oe;
        end
        if (!wr_n) begin
            mem[byte_bus ? a_q : {a_q[8:1], 1'b0}] <= shared_addr_data_port_out[7:0];
            if (!byte_bus) mem[{a_q[8:1], 1'b1}] <= shared_addr_data_port_out[15:8];
        end
    end
endmodule : xbc_ext_mem
`default_nettype wire
